// >>> verilog/rsrc_top.sv
// Strap decode, reference switching and output rate control
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Selected-ref alarm disqualifies current reference
// - Per-input alarms gate switching to other
// - Switching is non-revertive
// - Straps decode six connection kinds
// - First output rate follows its select pair
// - Four rates chosen from seven
// - Second output rate follows its pair
// - Outputs three, four fixed by straps
// - Straps 5:4 set realign edge
// - Straps 3:2 set input, interface
// - Straps 7:6 set lock, interface, divider
// - Odd divisor applies to all outputs
// - VDD with second alarm: 19.44 in, LVPECL
// - GND with drive: 77.76 in, CML
// - Example rate set row decodes correctly
// - Example fixed-output row decodes correctly
// - Example divider row: LVPECL, lock, five
// - Ethernet 125 uses divide by five
// - 125 with divide by three is invalid
module rsrc_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic first_ref_activity_alarm_in,
  input wire logic second_ref_activity_alarm_in,
  input wire logic selected_ref_activity_alarm_in,
  input wire logic pfd_phase_error_in,
  input wire logic [7:0] strap_in,
  input wire logic [1:0] first_output_rate_select_in,
  input wire logic [1:0] second_output_rate_select_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [3:0] strap_drive_output_out,
  output logic selected_ref_second_out,
  output logic config_ready_out,
  output logic config_invalid_out,
  output logic [2:0] input_freq_code_out,
  output logic first_second_lvpecl_out,
  output logic third_fourth_lvpecl_out,
  output logic lock_enable_out,
  output logic lock_indicator_out,
  output logic realign_edge_rising_out,
  output logic [2:0] odd_divisor_out,
  output logic [11:0] output_rate_codes_out,
  output logic first_clock_output_out,
  output logic second_clock_output_out,
  output logic third_clock_output_out,
  output logic fourth_clock_output_out
);
  typedef struct packed {
    rsrc_pkg::rsrc_state_t st;
    logic [7:0] cnt;
    logic [7:0] smp0;
    logic [7:0] smp1;
    logic [7:0] smp2;
    rsrc_pkg::rsrc_ref_t refsel;
    logic [3:0] drv;
    logic [1:0] r1_meta;
    logic [1:0] r1_sync;
    logic [1:0] r2_meta;
    logic [1:0] r2_sync;
    logic [11:0] avail;
    logic [2:0] rate1;
    logic [2:0] rate2;
    logic [2:0] rate3;
    logic [2:0] rate4;
    logic [2:0] div;
    logic [2:0] in_freq;
    logic if12;
    logic if34;
    logic lock_en;
    logic lock;
    logic edge_rise;
    logic bad;
    logic auto_en;
    logic wreq;
    logic [31:0] rdata;
  } rsrc_regs_t;

  localparam rsrc_regs_t RESET_VALUE = '{
    st: rsrc_pkg::ST_PROBE0,
    refsel: rsrc_pkg::REF_FIRST,
    drv: rsrc_pkg::DRV_RESET,
    div: rsrc_pkg::DIV_1,
    auto_en: rsrc_pkg::CTRL_AUTO_RESET,
    wreq: 1'b1,
    default: '0
  };

  rsrc_regs_t cur;
  rsrc_regs_t nxt;

  // Three probe phases tell ground, supply and each drive pin apart
  function automatic logic [3:0] strap_decode(input logic [2:0] seen);
    case (seen)
      3'h0: strap_decode = {1'b0, rsrc_pkg::SC_GND};
      3'h7: strap_decode = {1'b0, rsrc_pkg::SC_VDD};
      3'h1: strap_decode = {1'b0, rsrc_pkg::SC_FIRST_ALM};
      3'h2: strap_decode = {1'b0, rsrc_pkg::SC_SECOND_ALM};
      3'h4: strap_decode = {1'b0, rsrc_pkg::SC_DRIVE};
      3'h3: strap_decode = {1'b0, rsrc_pkg::SC_SEL_ALM};
      default: strap_decode = {1'b1, rsrc_pkg::SC_GND};
    endcase
  endfunction

  function automatic logic [3:0] probe_drive(input int ph);
    logic [3:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      r[k] = rsrc_pkg::DRV_PAT[k * 3 + ph];
    end
    probe_drive = r;
  endfunction

  function automatic logic [5:0] row_of(input logic [2:0] a, input logic [2:0] b);
    row_of = 6'(a) * 6'h6 + 6'(b);
  endfunction

  // Rows run through every four-of-seven set, fastest rates first
  function automatic logic [11:0] avail_of(input logic [5:0] row);
    logic [5:0] n;
    logic [11:0] r;
    n = '0;
    r = '0;
    for (int a = 0; a < 7; a++) begin
      for (int b = a + 1; b < 7; b++) begin
        for (int c = b + 1; c < 7; c++) begin
          for (int d = c + 1; d < 7; d++) begin
            if (n == row) begin
              r = {3'(6 - a), 3'(6 - b), 3'(6 - c), 3'(6 - d)};
            end
            n = n + 6'h1;
          end
        end
      end
    end
    avail_of = r;
  endfunction

  // Bit 1 of the code is pin A, bit 0 pin B
  function automatic logic [2:0] slot(input logic [11:0] av, input logic [1:0] ab);
    slot = av[3 * ab +: 3];
  endfunction

  function automatic logic [8:0] half_of(input logic [2:0] rate, input logic [2:0] dv);
    half_of = 9'((9'h1 << (3'h7 - rate)) * 9'(dv));
  endfunction

  logic [2:0] code [8];
  logic [3:0] dec;
  logic bad;
  logic [11:0] av_new;
  logic [5:0] r0;
  logic [5:0] r12;
  logic [5:0] r13;
  logic [3:0] t10;
  logic req;
  logic settled;

  always_comb begin
    nxt = cur;
    bad = 1'b0;
    dec = '0;
    for (int i = 0; i < 8; i++) begin
      dec = strap_decode({cur.smp2[i], cur.smp1[i], cur.smp0[i]});
      code[i] = dec[2:0];
      bad = bad | dec[3];
    end
    r0 = row_of(code[0], code[1]);
    r12 = row_of(code[4], code[5]);
    r13 = row_of(code[6], code[7]);
    av_new = avail_of(r0);
    req = avs_read_in | avs_write_in;
    settled = cur.cnt == 8'(rsrc_pkg::SETTLE_CYC - 1);

    // Input freq and outputs 1-2 interface by straps 3:2
    case ({code[2], code[3]})
      {rsrc_pkg::SC_GND, rsrc_pkg::SC_FIRST_ALM}: t10 = {rsrc_pkg::IN_155M52, 1'b0};
      {rsrc_pkg::SC_GND, rsrc_pkg::SC_SECOND_ALM}: t10 = {rsrc_pkg::IN_155M52, 1'b1};
      {rsrc_pkg::SC_GND, rsrc_pkg::SC_DRIVE}: t10 = {rsrc_pkg::IN_77M76, 1'b0};
      {rsrc_pkg::SC_GND, rsrc_pkg::SC_SEL_ALM}: t10 = {rsrc_pkg::IN_77M76, 1'b1};
      {rsrc_pkg::SC_VDD, rsrc_pkg::SC_GND}: t10 = {rsrc_pkg::IN_38M88, 1'b0};
      {rsrc_pkg::SC_VDD, rsrc_pkg::SC_VDD}: t10 = {rsrc_pkg::IN_38M88, 1'b1};
      {rsrc_pkg::SC_VDD, rsrc_pkg::SC_FIRST_ALM}: t10 = {rsrc_pkg::IN_19M44, 1'b0};
      {rsrc_pkg::SC_VDD, rsrc_pkg::SC_SECOND_ALM}: t10 = {rsrc_pkg::IN_19M44, 1'b1};
      {rsrc_pkg::SC_DRIVE, rsrc_pkg::SC_FIRST_ALM}: t10 = {rsrc_pkg::IN_125M, 1'b0};
      {rsrc_pkg::SC_DRIVE, rsrc_pkg::SC_SECOND_ALM}: t10 = {rsrc_pkg::IN_125M, 1'b1};
      default: begin
        t10 = {rsrc_pkg::IN_155M52, 1'b0};
        bad = 1'b1;
      end
    endcase

    nxt.r1_meta = first_output_rate_select_in;
    nxt.r1_sync = cur.r1_meta;
    nxt.r2_meta = second_output_rate_select_in;
    nxt.r2_sync = cur.r2_meta;
    nxt.lock = cur.lock_en & pfd_phase_error_in;

    case (cur.st)
      rsrc_pkg::ST_PROBE0: begin
        nxt.drv = probe_drive(0);
        nxt.cnt = cur.cnt + 8'h1;
        if (settled) begin
          nxt.smp0 = strap_in;
          nxt.cnt = '0;
          nxt.st = rsrc_pkg::ST_PROBE1;
        end
      end
      rsrc_pkg::ST_PROBE1: begin
        nxt.drv = probe_drive(1);
        nxt.cnt = cur.cnt + 8'h1;
        if (settled) begin
          nxt.smp1 = strap_in;
          nxt.cnt = '0;
          nxt.st = rsrc_pkg::ST_PROBE2;
        end
      end
      rsrc_pkg::ST_PROBE2: begin
        nxt.drv = probe_drive(2);
        nxt.cnt = cur.cnt + 8'h1;
        if (settled) begin
          nxt.smp2 = strap_in;
          nxt.cnt = '0;
          nxt.st = rsrc_pkg::ST_DECODE;
        end
      end
      rsrc_pkg::ST_DECODE: begin
        nxt.avail = av_new;
        nxt.in_freq = t10[3:1];
        nxt.if12 = t10[0];
        nxt.rate4 = slot(av_new, r12[rsrc_pkg::T12_FOURTH_CLOCK_OUTPUT_LSB +: 2]);
        nxt.rate3 = slot(av_new, r12[rsrc_pkg::T12_THIRD_CLOCK_OUTPUT_LSB +: 2]);
        nxt.edge_rise = r12[rsrc_pkg::T12_EDGE_BIT];
        nxt.lock_en = r13[rsrc_pkg::T13_LOCK_BIT];
        nxt.if34 = r13[rsrc_pkg::T13_IF_BIT];
        case (r13[rsrc_pkg::T13_DIV_LSB +: 2])
          2'h0: nxt.div = rsrc_pkg::DIV_5;
          2'h1: nxt.div = rsrc_pkg::DIV_3;
          2'h2: nxt.div = rsrc_pkg::DIV_7;
          default: nxt.div = rsrc_pkg::DIV_1;
        endcase
        if (r0 >= rsrc_pkg::AVAIL_ROW_UNUSED || r12 > rsrc_pkg::ROW_MAX
            || r13 > rsrc_pkg::ROW_MAX) begin
          bad = 1'b1;
        end
        // Ethernet plans only make sense undivided or divided to 125
        if ((t10[3:1] == rsrc_pkg::IN_125M || t10[3:1] == rsrc_pkg::IN_156M25)
            && nxt.div != rsrc_pkg::DIV_1 && nxt.div != rsrc_pkg::DIV_5) begin
          bad = 1'b1;
        end
        nxt.bad = bad;
        // Prefer the first input unless it is dead and the second is live
        if (first_ref_activity_alarm_in && !second_ref_activity_alarm_in) begin
          nxt.refsel = rsrc_pkg::REF_SECOND;
        end else begin
          nxt.refsel = rsrc_pkg::REF_FIRST;
        end
        nxt.st = rsrc_pkg::ST_RUN;
      end
      rsrc_pkg::ST_RUN: begin
        nxt.rate1 = slot(cur.avail, cur.r1_sync);
        nxt.rate2 = slot(cur.avail, cur.r2_sync);
        // Drive pins 0, 1 and 3 carry the alarms once straps are captured, pin 2 stays low
        nxt.drv = {selected_ref_activity_alarm_in, 1'b0,
                   second_ref_activity_alarm_in, first_ref_activity_alarm_in};
        // No way back on recovery: only a new failure moves the choice
        if (cur.auto_en && selected_ref_activity_alarm_in) begin
          if (cur.refsel == rsrc_pkg::REF_FIRST && !second_ref_activity_alarm_in) begin
            nxt.refsel = rsrc_pkg::REF_SECOND;
          end else if (cur.refsel == rsrc_pkg::REF_SECOND
                       && !first_ref_activity_alarm_in) begin
            nxt.refsel = rsrc_pkg::REF_FIRST;
          end
        end
      end
      default: begin
        nxt.st = rsrc_pkg::ST_PROBE0;
        nxt.cnt = '0;
      end
    endcase

    // Bus slave: one wait cycle, then a single accepting cycle
    nxt.wreq = 1'b1;
    if (req && cur.wreq) begin
      nxt.wreq = 1'b0;
      case (avs_address_in)
        rsrc_pkg::ADDR_CTRL: nxt.rdata = {31'h0, cur.auto_en};
        rsrc_pkg::ADDR_STATUS: nxt.rdata = {26'h0, cur.bad,
          cur.st == rsrc_pkg::ST_RUN, cur.refsel == rsrc_pkg::REF_SECOND,
          selected_ref_activity_alarm_in, second_ref_activity_alarm_in,
          first_ref_activity_alarm_in};
        rsrc_pkg::ADDR_CONFIG: nxt.rdata = {10'h0, cur.rate4, cur.rate3,
          cur.rate2, cur.rate1, cur.div, cur.in_freq, cur.if12, cur.if34,
          cur.lock_en, cur.edge_rise};
        default: nxt.rdata = '0;
      endcase
    end
    if (!cur.wreq && avs_write_in && avs_byteenable_in[0]
        && avs_address_in == rsrc_pkg::ADDR_CTRL) begin
      nxt.auto_en = avs_writedata_in[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cur <= RESET_VALUE;
    end else begin
      cur <= nxt;
    end
  end

  logic [11:0] rates_all;
  logic [3:0] clk_lvl;
  assign rates_all = {cur.rate4, cur.rate3, cur.rate2, cur.rate1};

  for (genvar g = 0; g < 4; g++) begin : gen_div
    rsrc_div_if dif ();
    assign dif.enable = rates_all[3 * g +: 3] != rsrc_pkg::RATE_OFF;
    assign dif.half = half_of(rates_all[3 * g +: 3], cur.div);
    assign clk_lvl[g] = dif.clk_level;
    rsrc_divider u_div (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .port_if(dif.div)
    );
  end

  assign avs_readdata_out = cur.rdata;
  assign avs_waitrequest_out = cur.wreq;
  assign strap_drive_output_out = cur.drv;
  // One-hot codes: the state bit itself is the flop behind each flag
  assign selected_ref_second_out = cur.refsel[1];
  assign config_ready_out = cur.st[4];
  assign config_invalid_out = cur.bad;
  assign input_freq_code_out = cur.in_freq;
  assign first_second_lvpecl_out = cur.if12;
  assign third_fourth_lvpecl_out = cur.if34;
  assign lock_enable_out = cur.lock_en;
  assign lock_indicator_out = cur.lock;
  assign realign_edge_rising_out = cur.edge_rise;
  assign odd_divisor_out = cur.div;
  assign output_rate_codes_out = rates_all;
  assign first_clock_output_out = clk_lvl[0];
  assign second_clock_output_out = clk_lvl[1];
  assign third_clock_output_out = clk_lvl[2];
  assign fourth_clock_output_out = clk_lvl[3];
endmodule
`default_nettype wire

// >>> verilog/rsrc_pkg.sv
// Shared constants and types for the strap and reference control block
package rsrc_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STRAP_SETTLE_NS = 20;
  localparam int SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HALF_W = 9;

  // Strap connection codes
  localparam logic [2:0] SC_GND = 3'h0;
  localparam logic [2:0] SC_VDD = 3'h1;
  localparam logic [2:0] SC_FIRST_ALM = 3'h2;
  localparam logic [2:0] SC_SECOND_ALM = 3'h3;
  localparam logic [2:0] SC_DRIVE = 3'h4;
  localparam logic [2:0] SC_SEL_ALM = 3'h5;

  // Probe patterns, three phases per drive pin, pin 3 in the top bits
  localparam logic [11:0] DRV_PAT = 12'h711;
  localparam logic [3:0] DRV_RESET = 4'h9;

  // Rate codes
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [2:0] RATE_19M44 = 3'h1;
  localparam logic [2:0] RATE_38M88 = 3'h2;
  localparam logic [2:0] RATE_77M76 = 3'h3;
  localparam logic [2:0] RATE_155M52 = 3'h4;
  localparam logic [2:0] RATE_311M04 = 3'h5;
  localparam logic [2:0] RATE_622M08 = 3'h6;
  localparam logic [HALF_W-1:0] HALF_RESET = 9'h002;

  // Expected input frequency codes
  localparam logic [2:0] IN_155M52 = 3'h0;
  localparam logic [2:0] IN_77M76 = 3'h1;
  localparam logic [2:0] IN_38M88 = 3'h2;
  localparam logic [2:0] IN_19M44 = 3'h3;
  localparam logic [2:0] IN_125M = 3'h4;
  localparam logic [2:0] IN_156M25 = 3'h5;

  localparam logic [2:0] DIV_1 = 3'h1;
  localparam logic [2:0] DIV_3 = 3'h3;
  localparam logic [2:0] DIV_5 = 3'h5;
  localparam logic [2:0] DIV_7 = 3'h7;

  // Strap row layouts
  localparam logic [5:0] AVAIL_ROW_UNUSED = 6'h23;
  localparam logic [5:0] ROW_MAX = 6'h1f;
  localparam int T12_THIRD_CLOCK_OUTPUT_LSB = 0;
  localparam int T12_FOURTH_CLOCK_OUTPUT_LSB = 2;
  localparam int T12_EDGE_BIT = 4;
  localparam int T13_LOCK_BIT = 0;
  localparam int T13_DIV_LSB = 1;
  localparam int T13_IF_BIT = 3;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h8;
  localparam logic CTRL_AUTO_RESET = 1'b1;

  typedef enum logic [4:0] {
    ST_PROBE0 = 5'b00001,
    ST_PROBE1 = 5'b00010,
    ST_PROBE2 = 5'b00100,
    ST_DECODE = 5'b01000,
    ST_RUN = 5'b10000
  } rsrc_state_t;

  typedef enum logic [1:0] {
    REF_FIRST = 2'b01,
    REF_SECOND = 2'b10
  } rsrc_ref_t;
endpackage

// >>> verilog/rsrc_div_if.sv
// Control link between the rate logic and one output divider
`timescale 1ns/1ps
`default_nettype none
interface rsrc_div_if;
  logic enable;
  logic [rsrc_pkg::HALF_W-1:0] half;
  logic clk_level;
  modport ctrl (output enable, output half, input clk_level);
  modport div (input enable, input half, output clk_level);
endinterface
`default_nettype wire

// >>> verilog/rsrc_divider.sv
// Output divider that takes a new ratio only at a period boundary
`timescale 1ns/1ps
`default_nettype none
module rsrc_divider (
  input wire logic clk_in,
  input wire logic nrst_in,
  rsrc_div_if.div port_if
);
  typedef struct packed {
    logic [rsrc_pkg::HALF_W-1:0] cnt;
    logic [rsrc_pkg::HALF_W-1:0] half;
    logic en;
    logic lvl;
  } rsrc_div_regs_t;

  rsrc_div_regs_t cur;
  rsrc_div_regs_t nxt;

  always_comb begin
    nxt = cur;
    if (!cur.en) begin
      nxt.cnt = '0;
      nxt.lvl = 1'b0;
      nxt.half = port_if.half;
      nxt.en = port_if.enable;
    end else if (cur.cnt == cur.half - 9'h1) begin
      nxt.cnt = '0;
      nxt.lvl = !cur.lvl;
      // Reload only after the high half, so no runt pulse appears
      if (cur.lvl) begin
        nxt.half = port_if.half;
        nxt.en = port_if.enable;
      end
    end else begin
      nxt.cnt = cur.cnt + 9'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cur <= '{cnt: '0, half: rsrc_pkg::HALF_RESET, en: 1'b0, lvl: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign port_if.clk_level = cur.lvl;
endmodule
`default_nettype wire

// >>> tb/rsrc_checker.sv
// Port-level assertions for strap decode, rate select and reference switching
`timescale 1ns/1ps
`default_nettype none
module rsrc_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic first_ref_activity_alarm_in,
  input wire logic second_ref_activity_alarm_in,
  input wire logic selected_ref_activity_alarm_in,
  input wire logic pfd_phase_error_in,
  input wire logic [1:0] first_output_rate_select_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [3:0] strap_drive_output_out,
  input wire logic selected_ref_second_out,
  input wire logic config_ready_out,
  input wire logic lock_enable_out,
  input wire logic lock_indicator_out,
  input wire logic [11:0] output_rate_codes_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic other_alarm;
  assign other_alarm = selected_ref_second_out ? first_ref_activity_alarm_in :
    second_ref_activity_alarm_in;
  sequence first_quiet;
    (config_ready_out && $stable(first_output_rate_select_in)) [*4];
  endsequence
  sequence decode_wait;
    !config_ready_out [*8] ##5 !config_ready_out;
  endsequence
  AST_BUS_ANSWER:
    assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request not answered");
  AST_BUS_ONE_CYCLE:
    assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  AST_DECODE_TIME:
    assert property ($rose(nrst_in) |-> decode_wait ##1 config_ready_out)
    else $error("decode not ready on time");
  AST_SWITCH:
    assert property (config_ready_out && selected_ref_activity_alarm_in && !other_alarm
      |=> selected_ref_second_out != $past(selected_ref_second_out))
    else $error("no switch away from failed source");
  AST_REFUSE:
    assert property (config_ready_out && selected_ref_activity_alarm_in && other_alarm
      |=> $stable(selected_ref_second_out))
    else $error("switched to alarmed source");
  AST_NO_REVERT:
    assert property (config_ready_out && !selected_ref_activity_alarm_in
      |=> $stable(selected_ref_second_out))
    else $error("source changed without alarm");
  AST_RATE_FIRST:
    assert property (first_quiet |-> $stable(output_rate_codes_out[2:0]))
    else $error("first rate moved with quiet pins");
  AST_FIXED_RATES:
    assert property (config_ready_out && $past(config_ready_out)
      |-> $stable(output_rate_codes_out[11:6]))
    else $error("fixed rates changed in run");
  AST_LOCK:
    assert property (lock_indicator_out == ($past(lock_enable_out) && $past(pfd_phase_error_in)))
    else $error("lock indicator wrong");
  AST_DRIVE_RUN:
    assert property (config_ready_out && $past(config_ready_out) |-> strap_drive_output_out ==
      {$past(selected_ref_activity_alarm_in), 1'b0, $past(second_ref_activity_alarm_in),
      $past(first_ref_activity_alarm_in)})
    else $error("drive pins wrong in run");
endmodule
`default_nettype wire

// >>> tb/rsrc_board.sv
// Board model: strap wiring and the two reference sources
`timescale 1ns/1ps
`default_nettype none
module rsrc_board (
  input wire logic [23:0] wiring_in,
  input wire logic [3:0] drive_in,
  input wire logic sel_second_in,
  input wire logic dead1_in,
  input wire logic dead2_in,
  output logic [7:0] strap_out,
  output logic sel_alarm_out
);
  // Detector sees only the source in use
  assign sel_alarm_out = sel_second_in ? dead2_in : dead1_in;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      case (wiring_in[3*n+:3])
        rsrc_pkg::SC_GND: strap_out[n] = 1'b0;
        rsrc_pkg::SC_VDD: strap_out[n] = 1'b1;
        rsrc_pkg::SC_FIRST_ALM: strap_out[n] = drive_in[0];
        rsrc_pkg::SC_SECOND_ALM: strap_out[n] = drive_in[1];
        rsrc_pkg::SC_DRIVE: strap_out[n] = drive_in[2];
        default: strap_out[n] = drive_in[3];
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/rsrc_top_bench.sv
// Bench: strap wirings, rate selects, source switching and register reads
`timescale 1ns/1ps
`default_nettype none
module rsrc_top_bench;
  logic clk_in, nrst_in, alm1, alm2, pfd, rd, wr, wreq, sel2nd, sel_alm, ready, bad;
  logic fs_lv, tf_lv, lock_en, lock_ind, edge_r;
  wire [3:0] clks;
  logic [1:0] sel1, sel2;
  logic [2:0] infreq, div;
  logic [3:0] addr, drive;
  logic [7:0] strap;
  logic [11:0] rates;
  logic [23:0] wiring;
  logic [31:0] wdata, rdata, q;
  int fails, cmp_count;

  always #2.5 clk_in = ~clk_in;

  rsrc_top DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .first_ref_activity_alarm_in(alm1),
    .second_ref_activity_alarm_in(alm2), .selected_ref_activity_alarm_in(sel_alm),
    .pfd_phase_error_in(pfd), .strap_in(strap), .first_output_rate_select_in(sel1),
    .second_output_rate_select_in(sel2), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .strap_drive_output_out(drive),
    .selected_ref_second_out(sel2nd), .config_ready_out(ready), .config_invalid_out(bad),
    .input_freq_code_out(infreq), .first_second_lvpecl_out(fs_lv),
    .third_fourth_lvpecl_out(tf_lv), .lock_enable_out(lock_en),
    .lock_indicator_out(lock_ind), .realign_edge_rising_out(edge_r),
    .odd_divisor_out(div), .output_rate_codes_out(rates), .first_clock_output_out(clks[0]),
    .second_clock_output_out(clks[1]), .third_clock_output_out(clks[2]),
    .fourth_clock_output_out(clks[3])
  );

  rsrc_board board (
    .wiring_in(wiring), .drive_in(drive), .sel_second_in(sel2nd), .dead1_in(alm1),
    .dead2_in(alm2), .strap_out(strap), .sel_alarm_out(sel_alm)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic wait_lvl(input int w, input logic v, output int n);
    n = 0;
    while (clks[w] !== v && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      wrap_up();
    end
  endtask

  // Leading high wait lets a reload pending in the current low half land first
  task automatic half_chk(input string what, input int w, input int exp);
    int n;
    wait_lvl(w, 1'b1, n);
    wait_lvl(w, 1'b0, n);
    wait_lvl(w, 1'b1, n);
    wait_lvl(w, 1'b0, n);
    chk(what, exp, n);
  endtask

  // Straps must stay put from release until decode
  task automatic do_reset(input logic [23:0] w);
    int n;
    @(posedge clk_in);
    wiring <= w;
    nrst_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 40) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic cfg_check(input logic [31:0] e);
    chk("invalid", 0, bad);
    chk("rate4", e[21:19], rates[11:9]);
    chk("rate3", e[18:16], rates[8:6]);
    chk("divisor", e[9:7], div);
    chk("input", e[6:4], infreq);
    chk("out12 type", e[3], fs_lv);
    chk("out34 type", e[2], tf_lv);
    chk("lock enable", e[1], lock_en);
    chk("edge", e[0], edge_r);
  endtask

  task automatic rate_walk(input int base, input logic [31:0] e, input int dv);
    for (int ab = 0; ab < 4; ab++) begin
      @(posedge clk_in);
      sel1 <= 2'(ab);
      sel2 <= 2'(3 - ab);
      repeat (4) @(posedge clk_in);
      chk("rate1", base + ab, rates[2:0]);
      chk("rate2", base + 3 - ab, rates[5:3]);
    end
    xfer(1'b0, 4'h8, 32'h0000_0000, q);
    chk("config reg", e | ((base + 3) << 10) | (base << 13), q);
    half_chk("first_clock_output half", 0, (1 << (4 - base)) * dv);
    half_chk("third_clock_output half", 2, (1 << (7 - e[18:16])) * dv);
  endtask

  initial begin
    clk_in = 1'b0;
    nrst_in = 1'b0;
    {alm1, alm2, pfd, rd, wr} = 5'h00;
    sel1 = 2'h0;
    sel2 = 2'h0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wiring = 24'h00_0000;
    fails = 0;
    cmp_count = 0;
    // Rate row 34, fixed row 17, divide row 9
    do_reset(24'h66_a825);
    cfg_check(32'h0001_0297);
    rate_walk(0, 32'h0001_0297, 5);
    chk("second_clock_output off", 0, clks[1]);
    chk("fourth_clock_output off", 0, clks[3]);
    xfer(1'b0, 4'h4, 32'h0000_0000, q);
    chk("status", 32'h0000_0010, q);
    xfer(1'b0, 4'hc, 32'h0000_0000, q);
    chk("unmapped", 0, q);
    xfer(1'b1, 4'h0, 32'h0000_0000, q);
    xfer(1'b0, 4'h0, 32'h0000_0000, q);
    chk("ctrl off", 0, q);
    xfer(1'b1, 4'h0, 32'h0000_0001, q);
    xfer(1'b0, 4'h0, 32'h0000_0000, q);
    chk("ctrl", 1, q);
    chk("start ref", 0, sel2nd);
    alm1 <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("switch", 1, sel2nd);
    alm1 <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("after recovery", 1, sel2nd);
    alm1 <= 1'b1;
    alm2 <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("both alarmed", 1, sel2nd);
    alm1 <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("switch back", 0, sel2nd);
    alm2 <= 1'b0;
    pfd <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("lock on", 1, lock_ind);
    $display("test strap set A done");
    alm1 <= 1'b1;
    // Rate row 0, fixed row 0, divide row 14
    do_reset(24'h48_0640);
    cfg_check(32'h001b_00bc);
    chk("start on second", 1, sel2nd);
    alm1 <= 1'b0;
    rate_walk(3, 32'h001b_00bc, 1);
    chk("lock off", 0, lock_ind);
    half_chk("second_clock_output half", 1, 16);
    half_chk("fourth_clock_output half", 3, 16);
    $display("test strap set B done");
    // Input 125 with divide by 3
    do_reset(24'h40_0700);
    chk("invalid", 1, bad);
    $display("test invalid set done");
    // Input 125 with divide by 5
    do_reset(24'h00_0700);
    chk("invalid", 0, bad);
    chk("divisor", rsrc_pkg::DIV_5, div);
    chk("input", rsrc_pkg::IN_125M, infreq);
    $display("test ethernet set done");
    wrap_up();
  end
endmodule

bind rsrc_top rsrc_chk u_chk (
  .clk_in, .nrst_in, .first_ref_activity_alarm_in, .second_ref_activity_alarm_in,
  .selected_ref_activity_alarm_in, .pfd_phase_error_in, .first_output_rate_select_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .strap_drive_output_out,
  .selected_ref_second_out, .config_ready_out, .lock_enable_out, .lock_indicator_out,
  .output_rate_codes_out
);
`default_nettype wire
